// file: etps_edge_det.sv
// Trigger pin synchroniser and polarity-selectable edge detector
`timescale 1ns/100ps
module etps_edge_det
  import etps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic trig_pin_i,
  input wire logic pol_rising_i,
  output logic edge_o
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  // ********************************
  // Synchroniser
  // ********************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= trig_pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= sync2_ff;
    end
  end

  // ********************************
  // Edge select
  // ********************************
  always_comb begin
    if (pol_rising_i == POL_RISING) begin
      edge_o = sync2_ff & ~prev_ff;
    end else begin
      edge_o = ~sync2_ff & prev_ff;
    end
  end

endmodule // etps_edge_det

// file: etps_pkg.sv
// Package with constants and types for the external trigger position sequencer
package etps_pkg;

  // Position setting encodings
  localparam logic POS_BEFORE_SAMPLING = 1'b0;
  localparam logic POS_BEFORE_SETUP = 1'b1;
  // Event setting encodings
  localparam logic EVT_ON_SWEEP = 1'b0;
  localparam logic EVT_ON_POINT = 1'b1;
  // Polarity encodings
  localparam logic POL_FALLING = 1'b0;
  localparam logic POL_RISING = 1'b1;

  // Default point count width
  localparam int PNT_W_DEF = 16;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_PRE_TUNE,
    ST_TUNE,
    ST_WAIT_PRE_ACQ,
    ST_ACQ,
    ST_ADVANCE
  } etps_state_t;

endpackage : etps_pkg

// file: etps_sequencer.sv
// Point sequencer that places the external trigger wait per position
`timescale 1ns/100ps
module etps_sequencer
  import etps_pkg::*;
#(
  parameter int PNT_W = PNT_W_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic trig_pin_i,
  input wire logic pol_rising_i,
  input wire logic pos_setup_i,
  input wire logic evt_point_i,
  input wire logic arm_i,
  input wire logic [PNT_W-1:0] num_points_i,
  input wire logic tune_done_i,
  input wire logic acq_done_i,
  output logic tune_start_o,
  output logic acq_start_o,
  output logic waiting_o,
  output logic busy_o,
  output logic sweep_done_o,
  output logic [PNT_W-1:0] point_idx_o
);

  initial begin
    if (PNT_W < 1 || PNT_W > 32) begin
      $error("PNT_W out of range");
    end
  end

  etps_state_t state_ff;
  etps_state_t nxt_state;
  logic [PNT_W-1:0] idx_ff;
  logic [PNT_W-1:0] last_ff;
  logic first_ff;
  logic trig_edge;
  logic need_wait;
  logic last_pt;
  logic tune_start_ff;
  logic acq_start_ff;
  logic done_ff;

  // ********************************
  // Trigger edge detection
  // ********************************
  etps_edge_det u_edge (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .trig_pin_i(trig_pin_i),
    .pol_rising_i(pol_rising_i),
    .edge_o(trig_edge)
  );

  // Trigger applies at every point, or only first point per sweep
  assign need_wait = (evt_point_i == EVT_ON_POINT) | first_ff;
  assign last_pt = (idx_ff == last_ff);

  // ********************************
  // State machine
  // ********************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (arm_i) begin
          if (pos_setup_i == POS_BEFORE_SETUP) begin
            nxt_state = ST_WAIT_PRE_TUNE;
          end else begin
            nxt_state = ST_TUNE;
          end
        end
      end
      ST_WAIT_PRE_TUNE: begin
        if (trig_edge) begin
          nxt_state = ST_TUNE;
        end
      end
      ST_TUNE: begin
        if (tune_done_i) begin
          if (pos_setup_i == POS_BEFORE_SAMPLING && need_wait) begin
            nxt_state = ST_WAIT_PRE_ACQ;
          end else begin
            nxt_state = ST_ACQ;
          end
        end
      end
      ST_WAIT_PRE_ACQ: begin
        if (trig_edge) begin
          nxt_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (acq_done_i) begin
          nxt_state = ST_ADVANCE;
        end
      end
      ST_ADVANCE: begin
        if (last_pt) begin
          nxt_state = ST_IDLE;
        end else if (pos_setup_i == POS_BEFORE_SETUP &&
                     evt_point_i == EVT_ON_POINT) begin
          nxt_state = ST_WAIT_PRE_TUNE;
        end else begin
          nxt_state = ST_TUNE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Edges outside wait states have no effect and are not stored
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ********************************
  // Point counter
  // ********************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_ff <= '0;
      last_ff <= '0;
      first_ff <= 1'b1;
    end else if (state_ff == ST_IDLE && arm_i) begin
      idx_ff <= '0;
      last_ff <= (num_points_i == '0) ? '0 : num_points_i - 1'b1;
      first_ff <= 1'b1;
    end else if (state_ff == ST_ADVANCE) begin
      first_ff <= 1'b0;
      if (!last_pt) begin
        idx_ff <= idx_ff + 1'b1;
      end
    end
  end

  // ********************************
  // Stage strobes
  // ********************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tune_start_ff <= 1'b0;
      acq_start_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      tune_start_ff <= (nxt_state == ST_TUNE) && (state_ff != ST_TUNE);
      acq_start_ff <= (nxt_state == ST_ACQ) && (state_ff != ST_ACQ);
      done_ff <= (state_ff == ST_ADVANCE) && last_pt;
    end
  end

  assign tune_start_o = tune_start_ff;
  assign acq_start_o = acq_start_ff;
  assign sweep_done_o = done_ff;
  assign point_idx_o = idx_ff;
  assign waiting_o = (state_ff == ST_WAIT_PRE_TUNE) ||
                     (state_ff == ST_WAIT_PRE_ACQ);
  assign busy_o = (state_ff != ST_IDLE);

  // ********************************
  // Assertions
  // ********************************
  property p_acq_after_tune;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      acq_start_o |-> $past(state_ff == ST_TUNE, 1) ||
                      $past(state_ff == ST_WAIT_PRE_ACQ, 1);
  endproperty
  a_acq_after_tune: assert property (p_acq_after_tune)
    else $error("acquire started without tuning");

  property p_pre_acq_wait;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_ff == ST_TUNE && tune_done_i && pos_setup_i == POS_BEFORE_SAMPLING
       && first_ff) |=> state_ff == ST_WAIT_PRE_ACQ;
  endproperty
  a_pre_acq_wait: assert property (p_pre_acq_wait)
    else $error("no wait before acquisition");

  property p_advance_tune;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_ff == ST_ADVANCE && !last_pt && pos_setup_i == POS_BEFORE_SAMPLING)
      |=> state_ff == ST_TUNE && tune_start_o;
  endproperty
  a_advance_tune: assert property (p_advance_tune)
    else $error("next point not tuned directly");

  property p_pre_tune_trig;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_ff == ST_WAIT_PRE_TUNE && trig_edge) |=> ##[0:1] tune_start_o;
  endproperty
  a_pre_tune_trig: assert property (p_pre_tune_trig)
    else $error("trigger did not start tuning");

  property p_setup_no_wait;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_ff == ST_TUNE && tune_done_i && pos_setup_i == POS_BEFORE_SETUP)
      |=> state_ff == ST_ACQ;
  endproperty
  a_setup_no_wait: assert property (p_setup_no_wait)
    else $error("pre-tune mode waited before acquire");

  property p_sweep_later;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (evt_point_i == EVT_ON_SWEEP && !first_ff) |-> !waiting_o;
  endproperty
  a_sweep_later: assert property (p_sweep_later)
    else $error("per-sweep waited at later point");

  property p_wait_holds;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (waiting_o && !trig_edge) |=> waiting_o;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("left wait without trigger");

  property p_ignore_edge;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (((state_ff == ST_ACQ && !acq_done_i) ||
        (state_ff == ST_TUNE && !tune_done_i)) && trig_edge)
      |=> state_ff == $past(state_ff);
  endproperty
  a_ignore_edge: assert property (p_ignore_edge)
    else $error("stray edge changed the sequence");

  property p_edge_pol;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      trig_edge |-> (u_edge.sync2_ff == pol_rising_i);
  endproperty
  a_edge_pol: assert property (p_edge_pol)
    else $error("edge of wrong polarity");

  c_pre_tune: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state_ff == ST_WAIT_PRE_TUNE ##1 state_ff == ST_TUNE);
  c_pre_acq: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state_ff == ST_WAIT_PRE_ACQ ##1 state_ff == ST_ACQ);
  c_done: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sweep_done_o);

endmodule // etps_sequencer

// file: etps_trig_src.sv
// Partner model: external equipment driving the trigger pin
`timescale 1ns/100ps
module etps_trig_src (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic pol_rising_i,
  input wire logic fire_i,
  output logic trig_pin_o
);
  // ****************
  // Pulse shaper
  // ****************
  logic [3:0] hold_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_ff <= 4'h0;
    end else if (fire_i && hold_ff == 4'h0) begin
      hold_ff <= 4'h8;
    end else if (hold_ff != 4'h0) begin
      hold_ff <= hold_ff - 4'h1;
    end
  end
  // Active level while holding, idle level otherwise
  assign trig_pin_o = pol_rising_i ^ (hold_ff == 4'h0);
endmodule // etps_trig_src

// file: ext_trigger_position_sequencer_bench.sv
// Self-checking bench for the trigger position sequencer
`timescale 1ns/100ps
module ext_trigger_position_sequencer_bench
  import etps_pkg::*;
;
  logic clk, rstn, trig_pin, pol, pos, evt, arm, tune_done, acq_done;
  logic fire, stray, tune_start, acq_start, waiting, busy, sweep_done;
  logic wait_q;
  logic [3:0] num, idx;
  logic [5:0] exp_q[$];
  int mismatches, n_checks, cyc;

  etps_sequencer #(.PNT_W(4)) uut (.sys_clk_i(clk), .rstn_i(rstn),
    .trig_pin_i(trig_pin), .pol_rising_i(pol), .pos_setup_i(pos),
    .evt_point_i(evt), .arm_i(arm), .num_points_i(num),
    .tune_done_i(tune_done), .acq_done_i(acq_done),
    .tune_start_o(tune_start), .acq_start_o(acq_start),
    .waiting_o(waiting), .busy_o(busy), .sweep_done_o(sweep_done),
    .point_idx_o(idx));
  etps_trig_src src (.sys_clk_i(clk), .rstn_i(rstn), .pol_rising_i(pol),
    .fire_i(fire | stray), .trig_pin_o(trig_pin));

  // ****************
  // Checking
  // ****************
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic take(input logic [5:0] seen);
    logic [5:0] e;
    e = 6'h3f;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
    end
    chk("event", {2'h0, e}, {2'h0, seen});
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    wait_q <= waiting;
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
    if (tune_start === 1'b1) take({2'h0, idx});
    if (tune_start === 1'b1) chk("busy", 8'h01, {7'h00, busy});
    if (sweep_done === 1'b1) chk("idle", 8'h00, {7'h00, busy});
    if (acq_start === 1'b1) take({2'h1, idx});
    if (waiting === 1'b1 && wait_q !== 1'b1) take({2'h2, idx});
    if (sweep_done === 1'b1) take(6'h30);
  end

  // ****************
  // Stage responders and trigger source control
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial forever begin
    @(posedge clk);
    if (tune_start === 1'b1) begin
      stray <= 1'b1;
      @(posedge clk);
      stray <= 1'b0;
      repeat (10 + $urandom % 4) @(posedge clk);
      tune_done <= 1'b1;
      @(posedge clk);
      tune_done <= 1'b0;
    end
  end

  initial forever begin
    @(posedge clk);
    if (acq_start === 1'b1) begin
      repeat ($urandom % 4) @(posedge clk);
      acq_done <= 1'b1;
      @(posedge clk);
      acq_done <= 1'b0;
    end
  end

  initial begin
    int lat;
    forever begin
      @(posedge clk);
      if (waiting === 1'b1) begin
        repeat ($urandom % 3) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        lat = 0;
        while (waiting === 1'b1 && lat < 20) begin
          @(posedge clk);
          lat++;
        end
        chk("latency", 8'h01, {7'h00, lat <= 8});
      end
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    int n, t;
    logic w;
    {rstn, pol, pos, evt, arm, tune_done, acq_done, fire, stray} = '0;
    {wait_q, num, mismatches, n_checks, cyc} = '0;
    void'($urandom(32'he207_e19b));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      pos <= c[0];
      evt <= c[1];
      pol <= c[2];
      n = (c == 3) ? 1 : 1 + $urandom % 4;
      num <= (c == 3) ? 4'h0 : n[3:0];
      repeat (6) @(posedge clk);
      for (int i = 0; i < n; i++) begin
        w = c[1] || i == 0;
        if (c[0] && w) exp_q.push_back({2'h2, i[3:0]});
        exp_q.push_back({2'h0, i[3:0]});
        if (!c[0] && w) exp_q.push_back({2'h2, i[3:0]});
        exp_q.push_back({2'h1, i[3:0]});
      end
      exp_q.push_back(6'h30);
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      repeat (3) @(posedge clk);
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      t = 0;
      while (sweep_done !== 1'b1 && t < 2000) begin
        @(posedge clk);
        t++;
      end
      chk("hang", 8'h00, {7'h00, t == 2000});
      @(posedge clk);
      chk("leftover", 8'h00, 8'(exp_q.size()));
      $display("test %0d done: pos %0d evt %0d pol %0d points %0d",
               c, c[0], c[1], c[2], n);
    end
    close_out();
  end
endmodule // ext_trigger_position_sequencer_bench
